// ### hw/pcd_pkg.sv
// package: constants, types and carriers of the pass-through command decoder
package pcd_pkg;
   // character codes, decimal base and register digit range
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_PLUS = 8'h2B;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_UA = 8'h41;
   localparam logic [7:0] CH_UZ = 8'h5A;
   localparam logic [7:0] CH_LA = 8'h61;
   localparam logic [7:0] CH_LZ = 8'h7A;
   localparam logic [7:0] CASE_OFS = 8'h20;
   localparam logic [7:0] CH_P = 8'h50;
   localparam logic [7:0] CH_T = 8'h54;
   localparam logic [3:0] DEC_BASE = 4'hA;
   localparam logic [3:0] REG_MIN = 4'h1;
   localparam logic [3:0] REG_MAX = 4'h9;
   // two-character codes, upper case
   localparam logic [15:0] CODE_ALT_PREFIX = 16'h5348;
   localparam logic [15:0] CODE_PRESET = 16'h4950;
   localparam logic [15:0] CODE_MASK_MAIN = 16'h524D;
   localparam logic [15:0] CODE_MASK_EXT1 = 16'h5245;
   localparam logic [15:0] CODE_MASK_EXT2 = 16'h5232;
   localparam logic [15:0] CODE_SV = 16'h5356;
   localparam logic [15:0] CODE_RC = 16'h5243;
   localparam logic [15:0] CODE_VR = 16'h5652;
   localparam logic [15:0] CODE_PL = 16'h504C;
   // pass-through targets and addressing
   localparam logic [7:0] TGT_NUM_SWEEP = 8'h13;
   localparam logic [7:0] TGT_NUM_PLOT = 8'h05;
   localparam logic [4:0] SEC_FLIP = 5'h01;
   localparam logic [4:0] PRI_ADDR_RST = 5'h10;
   // preset values
   localparam logic [15:0] SWEEP_PRESET_MS = 16'h00C8;
   localparam logic [2:0] POR_INIT = 3'h7;
   localparam logic [2:0] POR_FIRE = 3'h1;
   // register map, byte addresses
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_MASKS = 12'h008;
   localparam logic [11:0] REG_SWEEP = 12'h00C;
   localparam logic [11:0] REG_INT_STAT = 12'h010;
   localparam logic [11:0] REG_INT_EN = 12'h014;
   localparam logic [11:0] REG_INT_CLR = 12'h018;
   // event bits
   localparam int EV_SEL = 0;
   localparam int EV_EXIT = 1;
   localparam int EV_PRESET = 2;
   localparam int EV_MASK = 3;
   localparam int EV_N = 4;

   typedef enum logic [1:0] {TGT_NONE, TGT_SWEEP, TGT_PLOT} pcd_tgt_e;
   typedef enum logic [1:0] {LSN_NONE, LSN_PRI, LSN_SEC} pcd_lsn_e;

   typedef struct packed {
      logic vld;
      logic [7:0] ch;
   } pcd_char_s;

   typedef struct packed {
      logic vld;
      pcd_tgt_e tgt;
      logic [7:0] ch;
   } pcd_fwd_s;

   // codes that take a one-digit on/off suffix
   function automatic logic pcd_is_onoff(input logic [15:0] c);
      case (c)
         16'h414B, 16'h414C, 16'h4341, 16'h4349, 16'h4450,
         16'h4455, 16'h4649, 16'h4D44, 16'h4D50, 16'h5053,
         16'h5246, 16'h5250, 16'h534C: pcd_is_onoff = 1'h1;
         default: pcd_is_onoff = 1'h0;
      endcase
   endfunction
endpackage

// ### hw/pcd_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pcd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end

   assign q = s2_q;
endmodule // pcd_sync

// ### hw/pcd_dec_acc.sv
// decimal digit accumulator, value wraps at its width
`timescale 1ns/1ps
module pcd_dec_acc
   import pcd_pkg::*;
#(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // digit stream; fresh starts a new number with this digit
   input wire logic fresh,
   input wire logic stb,
   input wire logic [3:0] digit,
   // value
   output logic [W-1:0] val,
   output logic [W-1:0] val_nxt
);
   logic [W-1:0] val_q;
   logic [W-1:0] base;

   assign base = fresh ? '0 : val_q;
   assign val_nxt = W'(base * W'(DEC_BASE)) + W'(digit);

   always_ff @(posedge clk) begin
      if (srst)
         val_q <= '0;
      else if (stb)
         val_q <= val_nxt;
   end

   assign val = val_q;
endmodule // pcd_dec_acc

// ### hw/pcd_top.sv
// pass-through selector and sweeper command decoder with apb registers
`timescale 1ns/1ps
// Operation
// - on/off code suffix digit one switches on, zero switches off
// - save and recall codes take one register digit from one to nine
// - drop spaces, plus, stray characters; minus kept only for value codes
// - letters match regardless of case
// - three mask commands each load their own service-request mask
// - selection number 19 routes to sweeper, 05 to plotter
// - characters at secondary address go to the selected target
// - a new selection is accepted while addressed at the primary address and replaces the old one
// - secondary address is primary address with low bit inverted
// - addressing the primary address ends forwarding
// - selection string accepted bare or with carriage return, line feed
// - preset sets 200 ms sweep, square-wave on, rf from strap
module pcd_top
   import pcd_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // primary bus listener
   input wire logic bus_addr_stb,
   input wire logic [4:0] bus_addr,
   input wire pcd_char_s bus_char,
   // pins
   input wire logic preset_key_sweep,
   input wire logic preset_key_analyzer,
   input wire logic rf_strap,
   // forwarded character stream
   output pcd_fwd_s fwd,
   // decoded sweeper actions
   output logic code_stb,
   output logic [15:0] code,
   output logic code_shift,
   output logic onoff_stb,
   output logic onoff,
   output logic store_stb,
   output logic store_recall,
   output logic [3:0] store_reg,
   output logic value_neg_stb,
   output logic [7:0] mask_main,
   output logic [7:0] mask_ext1,
   output logic [7:0] mask_ext2,
   output logic preset_stb,
   output logic [15:0] sweep_time_ms,
   output logic sq_mod_on,
   output logic rf_on,
   output logic irq
);
   typedef enum logic [1:0] {PT_IDLE, PT_P, PT_T, PT_D} pcd_pt_e;
   typedef enum logic [1:0] {D_IDLE, D_L2, D_ARG} pcd_dec_e;

   // pins
   logic [2:0] pins_s;
   logic [1:0] key_prev_q;
   logic [1:0] key_rise;
   logic [2:0] por_q;

   pcd_sync #(.W(3)) u_sync (
      .clk(sys_clk),
      .srst(srst),
      .d({rf_strap, preset_key_analyzer, preset_key_sweep}),
      .q(pins_s)
   );

   assign key_rise = pins_s[1:0] & ~key_prev_q;

   // character classes after case folding
   logic is_lower;
   logic [7:0] up;
   logic is_dig;
   logic is_let;
   logic [3:0] dig;

   assign is_lower = bus_char.ch >= CH_LA && bus_char.ch <= CH_LZ;
   assign up = is_lower ? bus_char.ch - CASE_OFS : bus_char.ch;
   assign is_dig = up >= CH_0 && up <= CH_9;
   assign is_let = up >= CH_UA && up <= CH_UZ;
   assign dig = 4'(up - CH_0);

   // addressing and selection
   logic [4:0] pri_addr_q;
   logic [4:0] sec_addr;
   logic hit_pri;
   logic hit_sec;
   pcd_lsn_e listen_q;
   pcd_lsn_e lsn_d;
   pcd_tgt_e tgt_q;
   pcd_pt_e pt_q;
   pcd_pt_e pt_d;
   logic pri_char;
   logic sec_char;
   logic pt_stb;
   logic pt_commit;
   logic [7:0] pt_val;
   logic [7:0] pt_nxt;
   logic ev_exit;

   assign sec_addr = pri_addr_q ^ SEC_FLIP;
   assign hit_pri = bus_addr == pri_addr_q;
   assign hit_sec = bus_addr == sec_addr;
   assign lsn_d = hit_pri ? LSN_PRI : hit_sec ? LSN_SEC : LSN_NONE;
   assign ev_exit = bus_addr_stb & hit_pri & (listen_q == LSN_SEC);
   assign pri_char = bus_char.vld & (listen_q == LSN_PRI);
   assign sec_char = bus_char.vld & (listen_q == LSN_SEC)
      & (tgt_q != TGT_NONE);
   assign pt_stb = pri_char & is_dig & (pt_q == PT_T || pt_q == PT_D);
   // second digit ends the string; a trailing cr lf falls into idle
   assign pt_commit = pri_char & is_dig & (pt_q == PT_D);

   pcd_dec_acc #(.W(8)) u_pt_acc (
      .clk(sys_clk),
      .srst(srst),
      .fresh(pt_q == PT_T),
      .stb(pt_stb),
      .digit(dig),
      .val(pt_val),
      .val_nxt(pt_nxt)
   );

   always_comb begin
      pt_d = pt_q;
      if (pri_char) begin
         case (pt_q)
            PT_IDLE: pt_d = (up == CH_P) ? PT_P : PT_IDLE;
            PT_P: pt_d = (up == CH_T) ? PT_T
               : (up == CH_P) ? PT_P : PT_IDLE;
            PT_T: pt_d = is_dig ? PT_D : PT_IDLE;
            PT_D: pt_d = PT_IDLE;
            default: pt_d = PT_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         listen_q <= LSN_NONE;
         pt_q <= PT_IDLE;
      end else begin
         if (bus_addr_stb)
            listen_q <= lsn_d;
         pt_q <= pt_d;
      end
   end

   // a selection replaces the previous one at once
   always_ff @(posedge sys_clk) begin
      if (srst)
         tgt_q <= TGT_NONE;
      else if (pt_commit && pt_nxt == TGT_NUM_SWEEP)
         tgt_q <= TGT_SWEEP;
      else if (pt_commit && pt_nxt == TGT_NUM_PLOT)
         tgt_q <= TGT_PLOT;
   end

   // forwarding register, one character per character received
   pcd_fwd_s fwd_q;

   always_ff @(posedge sys_clk) begin
      if (srst)
         fwd_q <= '0;
      else
         fwd_q <= '{sec_char, tgt_q, bus_char.ch};
   end

   // sweeper character decoder
   logic dec_vld;
   pcd_dec_e d_q;
   pcd_dec_e d_d;
   logic [7:0] c1_q;
   logic [7:0] c1_d;
   logic [15:0] cur_q;
   logic [15:0] cur_d;
   logic [15:0] pair;
   logic shift_q;
   logic shift_d;
   logic mask_code;
   logic val_code;
   logic store_code;
   logic mask_pend_q;
   logic mask_stb;
   logic mask_ld;
   logic [7:0] mask_val;
   logic term;
   logic preset_cmd_go;
   logic code_go;
   logic onoff_go;
   logic store_go;
   logic neg_go;

   assign dec_vld = sec_char & (tgt_q == TGT_SWEEP);
   assign pair = {c1_q, up};
   assign mask_code = cur_q == CODE_MASK_MAIN || cur_q == CODE_MASK_EXT1
      || cur_q == CODE_MASK_EXT2;
   assign val_code = cur_q == CODE_VR || cur_q == CODE_PL;
   assign store_code = cur_q == CODE_SV || cur_q == CODE_RC;
   assign term = is_let || up == CH_CR || up == CH_LF;
   assign mask_stb = dec_vld & (d_q == D_ARG) & mask_code & is_dig;
   assign mask_ld = dec_vld & (d_q == D_ARG) & mask_code
      & term & mask_pend_q;

   pcd_dec_acc #(.W(8)) u_mask_acc (
      .clk(sys_clk),
      .srst(srst),
      .fresh(~mask_pend_q),
      .stb(mask_stb),
      .digit(dig),
      .val(mask_val),
      .val_nxt()
   );

   // spaces, plus signs and stray characters fall through every branch
   always_comb begin
      d_d = d_q;
      c1_d = c1_q;
      cur_d = cur_q;
      shift_d = shift_q;
      preset_cmd_go = 1'h0;
      code_go = 1'h0;
      onoff_go = 1'h0;
      store_go = 1'h0;
      neg_go = 1'h0;
      if (dec_vld) begin
         case (d_q)
            D_IDLE: begin
               if (is_let) begin
                  c1_d = up;
                  d_d = D_L2;
               end
            end
            D_L2: begin
               if (is_let || is_dig) begin
                  if (pair == CODE_ALT_PREFIX) begin
                     shift_d = 1'h1;
                     d_d = D_IDLE;
                  end else begin
                     code_go = 1'h1;
                     preset_cmd_go = pair == CODE_PRESET;
                     cur_d = pair;
                     shift_d = 1'h0;
                     d_d = (pair == CODE_PRESET) ? D_IDLE : D_ARG;
                  end
               end
            end
            D_ARG: begin
               if (is_dig && pcd_is_onoff(cur_q)) begin
                  onoff_go = dig <= REG_MIN;
                  d_d = D_IDLE;
               end else if (is_dig && store_code) begin
                  store_go = dig >= REG_MIN && dig <= REG_MAX;
                  d_d = D_IDLE;
               end else if (is_let) begin
                  c1_d = up;
                  d_d = D_L2;
               end else if (term) begin
                  d_d = D_IDLE;
               end else if (up == CH_MINUS && val_code) begin
                  neg_go = 1'h1;
               end
            end
            default: d_d = D_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         d_q <= D_IDLE;
         c1_q <= '0;
         cur_q <= '0;
         shift_q <= 1'h0;
      end else begin
         d_q <= d_d;
         c1_q <= c1_d;
         cur_q <= cur_d;
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst)
         mask_pend_q <= 1'h0;
      else if (mask_stb)
         mask_pend_q <= 1'h1;
      else if (mask_ld || code_go)
         mask_pend_q <= 1'h0;
   end

   // decoded action strobes
   logic code_stb_q;
   logic [15:0] code_q;
   logic code_shift_q;
   logic onoff_stb_q;
   logic onoff_q;
   logic store_stb_q;
   logic store_recall_q;
   logic [3:0] store_reg_q;
   logic neg_stb_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         code_stb_q <= 1'h0;
         code_q <= '0;
         code_shift_q <= 1'h0;
         onoff_stb_q <= 1'h0;
         onoff_q <= 1'h0;
         store_stb_q <= 1'h0;
         store_recall_q <= 1'h0;
         store_reg_q <= '0;
         neg_stb_q <= 1'h0;
      end else begin
         code_stb_q <= code_go;
         if (code_go) begin
            code_q <= cur_d;
            code_shift_q <= shift_q;
         end
         onoff_stb_q <= onoff_go;
         if (onoff_go)
            onoff_q <= dig == REG_MIN;
         store_stb_q <= store_go;
         if (store_go) begin
            store_recall_q <= cur_q == CODE_RC;
            store_reg_q <= dig;
         end
         neg_stb_q <= neg_go;
      end
   end

   // service-request masks
   logic [7:0] mask_main_q;
   logic [7:0] mask_ext1_q;
   logic [7:0] mask_ext2_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mask_main_q <= '0;
         mask_ext1_q <= '0;
         mask_ext2_q <= '0;
      end else if (mask_ld) begin
         if (cur_q == CODE_MASK_MAIN)
            mask_main_q <= mask_val;
         if (cur_q == CODE_MASK_EXT1)
            mask_ext1_q <= mask_val;
         if (cur_q == CODE_MASK_EXT2)
            mask_ext2_q <= mask_val;
      end
   end

   // preset from either key, the preset code, or once after reset
   logic preset_go;
   logic preset_stb_q;
   logic [15:0] sweep_time_q;
   logic sq_mod_q;
   logic rf_on_q;

   assign preset_go = preset_cmd_go | (|key_rise) | (por_q == POR_FIRE);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         por_q <= POR_INIT;
         key_prev_q <= '0;
         preset_stb_q <= 1'h0;
         sweep_time_q <= SWEEP_PRESET_MS;
         sq_mod_q <= 1'h1;
         rf_on_q <= 1'h0;
      end else begin
         por_q <= por_q >> 1;
         key_prev_q <= pins_s[1:0];
         preset_stb_q <= preset_go;
         if (preset_go) begin
            sweep_time_q <= SWEEP_PRESET_MS;
            sq_mod_q <= 1'h1;
            rf_on_q <= pins_s[2];
         end
      end
   end

   // apb slave, one wait state, registered answer
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic apb_acc;
   logic apb_ans;
   logic wr_en;
   logic addr_ok;
   logic [EV_N-1:0] ev;
   logic [EV_N-1:0] stat_q;
   logic [EV_N-1:0] en_q;
   logic [EV_N-1:0] clr;
   logic irq_q;

   assign apb_acc = psel & penable;
   assign apb_ans = apb_acc & ~pready_q;
   assign wr_en = apb_acc & pready_q & pwrite;
   assign addr_ok = paddr == REG_CTRL || paddr == REG_STATUS
      || paddr == REG_MASKS || paddr == REG_SWEEP
      || paddr == REG_INT_STAT || paddr == REG_INT_EN
      || paddr == REG_INT_CLR;
   assign rd_mux = (paddr == REG_CTRL) ? 32'(pri_addr_q)
      : (paddr == REG_STATUS) ? 32'({sec_addr, 4'h0, listen_q, tgt_q})
      : (paddr == REG_MASKS) ? 32'({mask_ext2_q, mask_ext1_q,
         mask_main_q})
      : (paddr == REG_SWEEP) ? 32'({rf_on_q, sq_mod_q, sweep_time_q})
      : (paddr == REG_INT_STAT) ? 32'(stat_q)
      : (paddr == REG_INT_EN) ? 32'(en_q) : '0;
   assign clr = (wr_en && paddr == REG_INT_CLR) ? pwdata[EV_N-1:0] : '0;

   always_comb begin
      ev = '0;
      ev[EV_SEL] = pt_commit;
      ev[EV_EXIT] = ev_exit;
      ev[EV_PRESET] = preset_go;
      ev[EV_MASK] = mask_ld;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q <= '0;
      end else begin
         pready_q <= apb_ans;
         if (apb_ans) begin
            pslverr_q <= ~addr_ok;
            prdata_q <= pwrite ? '0 : rd_mux;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pri_addr_q <= PRI_ADDR_RST;
         en_q <= '0;
         stat_q <= '0;
         irq_q <= 1'h0;
      end else begin
         if (wr_en && paddr == REG_CTRL)
            pri_addr_q <= pwdata[4:0];
         if (wr_en && paddr == REG_INT_EN)
            en_q <= pwdata[EV_N-1:0];
         stat_q <= (stat_q & ~clr) | ev;
         irq_q <= |(stat_q & en_q);
      end
   end

   // outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign fwd = fwd_q;
   assign code_stb = code_stb_q;
   assign code = code_q;
   assign code_shift = code_shift_q;
   assign onoff_stb = onoff_stb_q;
   assign onoff = onoff_q;
   assign store_stb = store_stb_q;
   assign store_recall = store_recall_q;
   assign store_reg = store_reg_q;
   assign value_neg_stb = neg_stb_q;
   assign mask_main = mask_main_q;
   assign mask_ext1 = mask_ext1_q;
   assign mask_ext2 = mask_ext2_q;
   assign preset_stb = preset_stb_q;
   assign sweep_time_ms = sweep_time_q;
   assign sq_mod_on = sq_mod_q;
   assign rf_on = rf_on_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_onoff_digit: assert property (
      dec_vld && d_q == D_ARG && pcd_is_onoff(cur_q) && up == CH_1
      |=> onoff_stb_q && onoff_q)
      else $error("on/off suffix one did not switch on");

   a_store_range: assert property (
      store_stb_q |-> store_reg_q >= REG_MIN && store_reg_q <= REG_MAX)
      else $error("store register out of range");

   a_space_drop: assert property (
      dec_vld && up == CH_SP |=> !code_stb_q && !onoff_stb_q
      && !store_stb_q && !neg_stb_q)
      else $error("space produced an action");

   a_case_fold: assert property (
      code_stb_q |-> !(code_q[15:8] >= CH_LA && code_q[15:8] <= CH_LZ)
      && !(code_q[7:0] >= CH_LA && code_q[7:0] <= CH_LZ))
      else $error("lower case letter not folded");

   a_mask_main: assert property (
      mask_ld && cur_q == CODE_MASK_MAIN |=> mask_main_q == $past(mask_val)
      && $stable(mask_ext1_q) && $stable(mask_ext2_q))
      else $error("main mask load wrong");

   a_target_sel: assert property (
      pt_commit && pt_nxt == TGT_NUM_SWEEP |=> tgt_q == TGT_SWEEP)
      else $error("selection 19 did not pick the sweeper");

   a_fwd_char: assert property (
      sec_char |=> fwd_q.vld && fwd_q.ch == $past(bus_char.ch))
      else $error("forwarded character lost or changed");

   a_sec_listen: assert property (
      bus_addr_stb && bus_addr == (pri_addr_q ^ SEC_FLIP)
      |=> listen_q == LSN_SEC)
      else $error("secondary address not recognised");

   a_exit_pass: assert property (
      bus_addr_stb && bus_addr == pri_addr_q
      |=> listen_q == LSN_PRI ##1 !fwd_q.vld)
      else $error("forwarding did not end");

   a_preset_vals: assert property (
      preset_go |=> preset_stb_q && sweep_time_q == SWEEP_PRESET_MS
      && sq_mod_q)
      else $error("preset values not applied");
endmodule // pcd_top

// ### verif/pcd_ctrl_model.sv
// controller model: addresses listeners and sends characters
`timescale 1ns/1ps
module pcd_ctrl_model
   import pcd_pkg::*;
(
   // clock
   input wire logic clk,
   // bus side
   output logic bus_addr_stb,
   output logic [4:0] bus_addr,
   output pcd_char_s bus_char
);
   initial begin
      bus_addr_stb = 1'b0;
      bus_addr = 5'h1F;
      bus_char = '0;
   end
   // the primary address ends forwarding
   task automatic addr(input logic [4:0] a);
      @(posedge clk);
      bus_addr_stb <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_addr_stb <= 1'b0;
      bus_addr <= ~a;
   endtask
   // idle data is scrambled, not held
   task automatic send(input string s, input int gap);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk);
         bus_char <= {1'b1, s[i]};
         repeat (gap) begin
            @(posedge clk);
            bus_char <= {1'b0, ~s[i]};
         end
      end
      @(posedge clk);
      bus_char <= {1'b0, ~bus_char.ch};
   endtask
endmodule // pcd_ctrl_model

// ### verif/pcd_top_tb_top.sv
// testbench: decoder and registers against fixed values, forwarding against a queue model
`timescale 1ns/1ps
module pcd_top_tb_top
   import pcd_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic bus_addr_stb;
   logic [4:0] bus_addr;
   pcd_char_s bus_char;
   logic preset_key_sweep, preset_key_analyzer, rf_strap;
   pcd_fwd_s fwd;
   logic code_stb, code_shift, onoff_stb, onoff, store_stb, store_recall;
   logic value_neg_stb, preset_stb, sq_mod_on, rf_on;
   logic [15:0] code, sweep_time_ms;
   logic [3:0] store_reg;
   logic [7:0] mask_main, mask_ext1, mask_ext2;
   int fails = 0, checked = 0, n_pre = 0, n_neg = 0, n_sto = 0;
   logic [10:0] q[$];
   string r = "";
   byte c;

   always #12.5 sys_clk = ~sys_clk;

   pcd_top uut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .bus_addr_stb, .bus_addr, .bus_char,
      .preset_key_sweep, .preset_key_analyzer, .rf_strap, .fwd, .code_stb,
      .code, .code_shift, .onoff_stb, .onoff, .store_stb, .store_recall,
      .store_reg, .value_neg_stb, .mask_main, .mask_ext1, .mask_ext2,
      .preset_stb, .sweep_time_ms, .sq_mod_on, .rf_on, .irq);
   pcd_ctrl_model ctl (.clk(sys_clk), .bus_addr_stb, .bus_addr, .bus_char);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // answer read as it stood at the edge; release right after it
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // send while forwarding, expecting each char on fwd
   task automatic fs(input string s, input logic [1:0] t, input int g);
      for (int i = 0; i < s.len(); i++) q.push_back({1'b1, t, s[i]});
      ctl.send(s, g);
   endtask

   always @(posedge sys_clk) begin
      if (srst === 1'b0) begin
         n_pre += preset_stb;
         n_neg += value_neg_stb;
         n_sto += store_stb;
         if (fwd.vld === 1'b1) begin
            chk(fwd, q.size() > 0 ? q.pop_front() : 11'h7FF);
         end
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      end_sim();
   end

   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {preset_key_sweep, preset_key_analyzer, rf_strap} = 3'b001;
      void'($urandom(32'h71ea_6bd4));
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      wt(6);
      chk(n_pre, 1);
      apb(0, REG_CTRL, 0);
      chk(rd, 32'h0000_0010);
      apb(0, REG_SWEEP, 0);
      chk(rd, 32'h0003_00C8);
      apb(0, 12'h020, 0);
      chk(er, 1);
      apb(1, REG_CTRL, 32'h0000_0007);
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h0000_0600);
      apb(1, REG_CTRL, 32'h0000_0010);
      ctl.addr(5'h10);
      ctl.send("pt42\r\n", 0);
      ctl.send("pt19\r\n", 1);
      wt(3);
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h0000_1105);
      ctl.addr(5'h11);
      fs("rf1", 1, 0);
      wt(3);
      chk({code, onoff}, {16'h5246, 1'b1});
      fs("R F0", 1, 2);
      wt(3);
      chk(onoff, 0);
      fs("SHrc", 1, 0);
      wt(3);
      chk({code, code_shift}, {16'h5243, 1'b1});
      fs("sv9rc3rc0", 1, 0);
      wt(3);
      chk({n_sto[3:0], store_recall, store_reg}, 9'h053);
      fs("RM12RE34R256\r\n", 1, 0);
      wt(3);
      chk({mask_ext2, mask_ext1, mask_main}, 24'h38_220C);
      fs("VR-5 FA-5+", 1, 0);
      wt(3);
      chk(n_neg, 1);
      fs("ip", 1, 0);
      wt(6);
      chk(n_pre, 2);
      ctl.addr(5'h10);
      ctl.send("XY", 0);
      wt(3);
      apb(0, REG_STATUS, 0);
      chk(rd[3:2], 2'h1);
      ctl.send("PT05", 0);
      ctl.addr(5'h11);
      for (int i = 0; i < 16; i++) begin
         c = 8'(1 + $urandom % 255);
         r = {r, string'(c)};
      end
      fs(r, 2, $urandom % 3);
      wt(4);
      chk(q.size(), 0);
      apb(0, REG_INT_STAT, 0);
      chk({rd[30:0], irq}, 32'h0000_001E);
      apb(1, REG_INT_EN, 32'h0000_0002);
      wt(2);
      chk(irq, 1);
      apb(1, REG_INT_CLR, 32'h0000_0002);
      wt(2);
      apb(0, REG_INT_STAT, 0);
      chk({rd[30:0], irq}, 32'h0000_001A);
      rf_strap <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         {preset_key_analyzer, preset_key_sweep} <= 2'(k + 1);
         wt(5);
         @(posedge sys_clk);
         {preset_key_analyzer, preset_key_sweep} <= 2'b00;
         wt(8);
         chk(n_pre, 3 + k);
      end
      apb(0, REG_SWEEP, 0);
      chk(rd, 32'h0001_00C8);
      chk({rf_on, sq_mod_on, sweep_time_ms}, 32'h0001_00C8);
      end_sim();
   end
endmodule // pcd_top_tb_top
